// ==== ckw_counter.sv ====
// Free-running timeout counter with power-of-four limit
`timescale 1ns/1ns
`default_nettype none
`include "ckw_defines.svh"
module ckw_counter
  import ckw_pkg::*;
#(
  parameter int CNT_W    = 20,
  parameter int EXP_BASE = `CKW_EXP_BASE
) (
  input  wire logic            clk_i,
  input  wire logic            clear_i,
  input  wire logic            run_i,
  input  wire ckw_interval_t   interval_i,
  output logic [CNT_W-1:0]     count_o,
  output logic                 expire_o
);
  initial begin
    if (CNT_W < EXP_BASE + 14 || CNT_W > 63 || EXP_BASE < 1)
      $error("ckw_counter: counter too narrow for the longest interval");
  end

  // Timeout is 2^(EXP_BASE + 2n) cycles, which is 4^(3+n) at the default EXP_BASE of 6
  wire logic [5:0]       shift = 6'(EXP_BASE) + 6'(`CKW_EXP_STEP * interval_i);
  wire logic [CNT_W-1:0] last  = ~({CNT_W{1'b1}} << shift);

  assign expire_o = run_i && (count_o == last);

  always_ff @(posedge clk_i) begin
    if (clear_i)
      count_o <= '0;
    else if (run_i)
      count_o <= count_o + 1'b1;
  end
endmodule
`default_nettype wire

// ==== ckw_defines.svh ====
// Register map, key values, field positions and timing counts of the keyed watchdog
`ifndef CKW_DEFINES_SVH
`define CKW_DEFINES_SVH
`define CKW_OFS_CONTROL   4'h0
`define CKW_OFS_STATUS    4'h4
`define CKW_KEY_KICK      8'hA5
`define CKW_KEY_DIS_FIRST 8'hDE
`define CKW_KEY_DIS_LAST  8'hAD
`define CKW_KEY_LOCK      8'hFF
`define CKW_CMD_BIT       7
`define CKW_INTV_MSB      2
`define CKW_INTV_RESET    3'h7
`define CKW_STS_EN_BIT    0
`define CKW_STS_LOCK_BIT  1
`define CKW_DIS_WINDOW    3'h4
`define CKW_EXP_BASE      6
`define CKW_EXP_STEP      2
`endif

// ==== ckw_pkg.sv ====
// Types shared by the keyed watchdog files
package ckw_pkg;
  typedef enum logic {CKW_IDLE, CKW_ARMED} ckw_dis_state_t;
  typedef logic [2:0] ckw_interval_t;
endpackage

// ==== ckw_watchdog.sv ====
// Keyed watchdog timer with classic Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "ckw_defines.svh"
module ckw_watchdog
  import ckw_pkg::*;
#(
  parameter int CNT_W    = 20,
  parameter int EXP_BASE = `CKW_EXP_BASE
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             sys_rst_o
);
  ckw_interval_t    interval;
  logic             enabled;
  logic             locked;
  ckw_dis_state_t   dis_state;
  ckw_dis_state_t   next_dis_state;
  logic [2:0]       gap;
  logic [CNT_W-1:0] count;
  logic             expire;

  // Bus decode; a write takes effect on the edge where ack is seen high
  wire logic req      = wb_cyc_i && wb_stb_i;
  wire logic hit_ctrl = (wb_adr_i == `CKW_OFS_CONTROL);
  wire logic hit_sts  = (wb_adr_i == `CKW_OFS_STATUS);
  wire logic wr_ctrl  = req && wb_ack_o && wb_we_i && hit_ctrl && wb_sel_i[0];
  wire logic [7:0] wbyte = wb_dat_i[7:0];
  wire logic is_cmd   = wbyte[`CKW_CMD_BIT];
  wire logic wr_intv  = wr_ctrl && !is_cmd;
  wire logic wr_kick  = wr_ctrl && (wbyte == `CKW_KEY_KICK);
  wire logic wr_first = wr_ctrl && (wbyte == `CKW_KEY_DIS_FIRST);
  wire logic wr_last  = wr_ctrl && (wbyte == `CKW_KEY_DIS_LAST);
  wire logic wr_lock  = wr_ctrl && (wbyte == `CKW_KEY_LOCK);

  // Gap holds cycles since the first key minus one, so gap <= 3 means within four
  wire logic in_window = (dis_state == CKW_ARMED) && ({1'b0, gap} < {1'b0, `CKW_DIS_WINDOW});
  wire logic disable_go = wr_last && in_window && !locked;

  // A kick in the same cycle as overflow wins; the count was serviced in time
  wire logic fire      = expire && !wr_kick;
  wire logic state_rst = rst_i || fire;

  wire logic [31:0] rd_data = hit_ctrl ? {29'h0, interval} :
                              hit_sts  ? {30'h0, locked, enabled} : 32'h0;

  always_comb begin
    next_dis_state = dis_state;
    case (dis_state)
      CKW_IDLE:  if (wr_first && !locked) next_dis_state = CKW_ARMED;
      CKW_ARMED: if (wr_ctrl && !wr_first) next_dis_state = CKW_IDLE;
                 else if (!wr_first && !in_window) next_dis_state = CKW_IDLE;
      default:   next_dis_state = CKW_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (state_rst) begin
      interval  <= `CKW_INTV_RESET;
      enabled   <= 1'b1;
      locked    <= 1'b0;
      dis_state <= CKW_IDLE;
      gap       <= 3'h0;
    end else begin
      // Unknown keys skip every branch below; dis_state still drops to CKW_IDLE if armed
      if (wr_intv)
        interval <= wbyte[`CKW_INTV_MSB:0];
      if (wr_kick)
        enabled <= 1'b1;
      else if (disable_go)
        enabled <= 1'b0;
      if (wr_lock)
        locked <= 1'b1;
      dis_state <= next_dis_state;
      gap       <= wr_first ? 3'h0 : (gap == 3'h7 ? gap : gap + 3'h1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      sys_rst_o <= 1'b0;
    else
      sys_rst_o <= fire;
  end

  ckw_counter #(
    .CNT_W    (CNT_W),
    .EXP_BASE (EXP_BASE)
  ) u_counter (
    .clk_i      (clk_i),
    .clear_i    (state_rst || wr_kick),
    .run_i      (enabled),
    .interval_i (interval),
    .count_o    (count),
    .expire_o   (expire)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_kick;
    wr_kick |=> enabled && (count == '0);
  endproperty
  a_kick: assert property (p_kick) else $error("kick did not enable and clear");

  property p_reset;
    $fell(rst_i) |-> enabled && !locked && (interval == 3'h7) && (count == '0);
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_dis_ok;
    (wr_first && !locked) ##3 (wr_last && !wr_first) |=> !enabled;
  endproperty
  a_dis_ok: assert property (p_dis_ok) else $error("timely disable ignored");

  // Second key exactly four cycles after the first is still inside the window
  property p_dis_edge;
    (wr_first && !locked) ##1 (!wr_ctrl && !fire)[*3] ##1 (wr_last && !fire) |=> !enabled;
  endproperty
  a_dis_edge: assert property (p_dis_edge) else $error("disable at window edge ignored");

  property p_dis_late;
    wr_first ##1 (!wr_first && !wr_kick && !fire)[*4] ##1 wr_last |=> enabled == $past(enabled);
  endproperty
  a_dis_late: assert property (p_dis_late) else $error("late disable accepted");

  property p_locked;
    locked && !wr_kick && !fire |=> enabled == $past(enabled) && locked;
  endproperty
  a_locked: assert property (p_locked) else $error("disable while locked");

  property p_lock_only;
    wr_lock && !fire && enabled |=> locked && enabled && (count == $past(count) + 1'b1);
  endproperty
  a_lock_only: assert property (p_lock_only) else $error("lockout touched counter");

  property p_bad_key;
    wr_ctrl && is_cmd && !wr_kick && !wr_first && !wr_last && !wr_lock && !fire
      |=> $stable(interval) && $stable(enabled) && $stable(locked);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("unknown key changed state");

  property p_read;
    wb_ack_o && !wb_we_i && hit_ctrl && !sys_rst_o |-> wb_dat_o == {29'h0, interval};
  endproperty
  a_read: assert property (p_read) else $error("control read wrong");

  property p_timeout;
    (interval == `CKW_INTV_RESET) && enabled && (count == '0) && !wr_kick ##1 (!wr_ctrl)[*8]
      |-> (count == CNT_W'(8));
  endproperty
  a_timeout: assert property (p_timeout) else $error("counter not counting");

  property p_expire;
    sys_rst_o |-> $past(enabled) && $past(expire) && enabled && (count == '0);
  endproperty
  a_expire: assert property (p_expire) else $error("reset without overflow");

  property p_ack;
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

  c_disable: cover property (disable_go);
  c_expire:  cover property (sys_rst_o);
  c_lock:    cover property (locked && wr_last);
  c_kick:    cover property (wr_kick && !enabled);
endmodule
`default_nettype wire

// ==== test_ckw_watchdog.sv ====
// Self-checking testbench for the keyed watchdog
`timescale 1ns/1ns
`default_nettype none
`include "ckw_defines.svh"
module test_ckw_watchdog import ckw_pkg::*;;
  // Short counts keep the overflow runs to a few dozen cycles
  localparam int EB    = 2;
  localparam int LIMIT = 4000;
  logic          clk_i, rst_i, cyc, stb, we, srst, ack;
  logic [3:0]    adr, sel;
  logic [7:0]    r;
  logic [31:0]   dat, rdat, w32;
  int            seed, cyc_n, n_rst, rst_t, n_fail, num_checks, k;
  int            m_intv, m_en, m_lock, m_arm, m_arm_t, m_kick_t, m_nrst;

  ckw_watchdog #(
    .CNT_W    (16),
    .EXP_BASE (EB)
  ) ckw_watchdog_i (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (cyc),
    .wb_stb_i  (stb),
    .wb_we_i   (we),
    .wb_adr_i  (adr),
    .wb_sel_i  (sel),
    .wb_dat_i  (dat),
    .wb_dat_o  (rdat),
    .wb_ack_o  (ack),
    .sys_rst_o (srst)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Edge stamps: a value read at an edge is the count of edges before it
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (srst) begin
      n_rst <= n_rst + 1;
      rst_t <= cyc_n;
    end
    if (cyc_n == LIMIT) begin
      n_fail = n_fail + 1;
      $display("mismatch timeout expected %0d seen %0d", LIMIT - 1, cyc_n);
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (exp !== got) begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic model_reset();
    m_intv = `CKW_INTV_RESET;
    m_en   = 1;
    m_lock = 0;
    m_arm  = 0;
  endtask

  // Called just after an edge; holds the request until ack is sampled high
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] b, output logic [31:0] rd,
                     output int stamp);
    logic [31:0] w;
    w = $random(seed);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= wr;
    adr <= a;
    sel <= 4'hF;
    dat <= {w[31:8], b};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd    = rdat;
    stamp = cyc_n;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr_ctrl(input logic [7:0] b);
    int s;
    bus(1'b1, `CKW_OFS_CONTROL, b, w32, s);
    if (!b[7])
      m_intv = b[2:0];
    else if (b == `CKW_KEY_KICK) begin
      m_en     = 1;
      m_kick_t = s;
    end else if (b == `CKW_KEY_DIS_LAST && m_arm == 1 && m_lock == 0 && s - m_arm_t <= 4)
      m_en = 0;
    else if (b == `CKW_KEY_LOCK)
      m_lock = 1;
    m_arm = (b == `CKW_KEY_DIS_FIRST && m_lock == 0) ? 1 : 0;
    if (b == `CKW_KEY_DIS_FIRST)
      m_arm_t = s;
  endtask

  task automatic read_all();
    int s;
    bus(1'b0, `CKW_OFS_CONTROL, 8'h00, w32, s);
    check("interval", m_intv, w32);
    bus(1'b0, `CKW_OFS_STATUS, 8'h00, w32, s);
    check("status", 32'(m_lock * 2 + m_en), w32);
  endtask

  task automatic disable_seq(input int extra);
    wr_ctrl(`CKW_KEY_DIS_FIRST);
    repeat (extra) @(posedge clk_i);
    wr_ctrl(`CKW_KEY_DIS_LAST);
  endtask

  // Overflow is due 4^(1+n) cycles (2^(EB + 2n)) after the kick edge, seen one edge later
  task automatic expect_fire(input int n);
    int n0, exp;
    n0  = n_rst;
    exp = m_kick_t + (1 << (EB + 2 * n)) + 1;
    while (n_rst == n0 && cyc_n <= exp + 2)
      @(posedge clk_i);
    check("overflow edge", exp, rst_t);
    m_nrst = m_nrst + 1;
    model_reset();
  endtask

  initial begin
    seed       = 32'h56625ead;
    cyc_n      = 0;
    n_rst      = 0;
    rst_t      = -1;
    n_fail     = 0;
    num_checks = 0;
    m_nrst     = 0;
    m_kick_t   = 0;
    m_arm_t    = 0;
    model_reset();
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    sel   = 4'h0;
    dat   = 32'h0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    read_all();
    for (k = 0; k < 6; k++) begin
      w32 = $random(seed);
      wr_ctrl({1'b0, w32[6:0]});
      read_all();
    end
    disable_seq(0);
    read_all();
    wr_ctrl(8'h01);
    wr_ctrl(`CKW_KEY_KICK);
    for (k = 0; k < 5; k++) begin
      repeat (4) @(posedge clk_i);
      wr_ctrl(`CKW_KEY_KICK);
    end
    check("kicked overflows", m_nrst, n_rst);
    expect_fire(1);
    read_all();
    for (k = 0; k < 3; k++) begin
      disable_seq(0);
      wr_ctrl(8'(k));
      wr_ctrl(`CKW_KEY_KICK);
      expect_fire(k);
    end
    disable_seq(1);
    read_all();
    wr_ctrl(`CKW_KEY_KICK);
    disable_seq(2);
    read_all();
    for (k = 0; k < 4; k++) begin
      w32 = $random(seed);
      r   = {1'b1, w32[6:0]};
      if (r == `CKW_KEY_KICK || r == `CKW_KEY_DIS_FIRST || r == `CKW_KEY_DIS_LAST || r == `CKW_KEY_LOCK)
        r = 8'h80;
      wr_ctrl(r);
      read_all();
    end
    disable_seq(0);
    wr_ctrl(`CKW_KEY_LOCK);
    read_all();
    wr_ctrl(8'h02);
    wr_ctrl(`CKW_KEY_KICK);
    wr_ctrl(`CKW_KEY_LOCK);
    disable_seq(0);
    read_all();
    expect_fire(2);
    read_all();
    wr_ctrl(8'h03);
    wr_ctrl(`CKW_KEY_LOCK);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    model_reset();
    read_all();
    check("overflow count", m_nrst, n_rst);
    results();
  end
endmodule
`default_nettype wire
